// ===== stl_pkg.sv
// package of instruction codes, field positions and widths for the skip and timer-load block
package stl_pkg;
	localparam int STL_IW       = 10;          // instruction word width
	localparam int STL_NW       = 4;           // data nibble width
	localparam int STL_PW       = 8;           // port D width
	localparam int STL_TW       = 8;           // timer 1 width
	localparam logic [9:0] STL_OP_CARRY  = 10'h02F; // skip_if_carry_zero
	localparam logic [9:0] STL_OP_PORT   = 10'h02B; // skip_if_port_bit_zero
	localparam logic [9:0] STL_OP_TLOAD  = 10'h230; // load_timer_one_from_acc_aux
	localparam logic [9:0] STL_OP_MBIT   = 10'h020; // skip_if_mem_bit_zero base, bits 1:0 hold j
	localparam logic [9:0] STL_MBIT_MASK = 10'h3FC; // opcode bits compared for the memory-bit skip
	localparam int STL_J_LSB    = 0;           // bit select field position
	localparam int STL_Y_MSB    = 2;           // top register Y bit used to pick the port pin, bits 2:0
	localparam logic [7:0] STL_TIMER_RST = 8'h00;   // timer and reload reset value
	typedef enum logic [1:0] {
		STL_EXEC   = 2'b00,
		STL_PORT2  = 2'b01,
		STL_SKIP   = 2'b11
	} stl_state_t;
endpackage

// ===== stl_decode.sv
// opcode decoder: classifies one instruction word
`timescale 1ns/1ns
module stl_decode
	import stl_pkg::*;
(
	input  wire logic [stl_pkg::STL_IW-1:0] instr_in,
	output logic                            is_mbit_out,
	output logic                            is_carry_out,
	output logic                            is_port_out,
	output logic                            is_tload_out,
	output logic [1:0]                      bit_sel_out
);
	// pattern compare on the fetched word
	assign is_mbit_out  = (instr_in & STL_MBIT_MASK) == STL_OP_MBIT;
	assign is_carry_out = instr_in == STL_OP_CARRY;
	assign is_port_out  = instr_in == STL_OP_PORT;
	assign is_tload_out = instr_in == STL_OP_TLOAD;
	assign bit_sel_out  = instr_in[STL_J_LSB+1:STL_J_LSB];
endmodule

// ===== stl_core.sv
// execution of the bit skips and the timer 1 load
`timescale 1ns/1ns
module stl_core
	import stl_pkg::*;
#(
	parameter int PORT_W = 8
)
(
	input  wire logic                        ref_clk_in,
	input  wire logic                        rst_n_in,
	input  wire logic                        instr_valid_in,
	input  wire logic [stl_pkg::STL_IW-1:0]  instr_in,
	input  wire logic [stl_pkg::STL_NW-1:0]  mem_nibble_in,
	input  wire logic                        carry_flag_in,
	input  wire logic [PORT_W-1:0]           port_d_in,
	input  wire logic [stl_pkg::STL_NW-1:0]  reg_y_in,
	input  wire logic [stl_pkg::STL_NW-1:0]  acc_in,
	input  wire logic [stl_pkg::STL_NW-1:0]  aux_in,
	output logic                             skip_out,
	output logic                             busy_out,
	output logic                             carry_flag_out,
	output logic                             timer_load_out,
	output logic [stl_pkg::STL_TW-1:0]       timer_one_count_out,
	output logic [stl_pkg::STL_TW-1:0]       timer_one_reload_out
);
	import stl_pkg::*;

	stl_state_t            state_r, state_nxt;
	logic                  is_mbit, is_carry, is_port, is_tload;
	logic [1:0]            bit_sel;
	logic                  skip_r, busy_r, carry_r, tload_r;
	logic [STL_TW-1:0]     count_r, reload_r;

	stl_decode u_dec (
		.instr_in     (instr_in),
		.is_mbit_out  (is_mbit),
		.is_carry_out (is_carry),
		.is_port_out  (is_port),
		.is_tload_out (is_tload),
		.bit_sel_out  (bit_sel)
	);

	// qualification: words act in the execute state, and the port skip's second word acts in the port-wait state
	wire in_exec   = instr_valid_in && state_r == STL_EXEC;
	wire in_skip   = instr_valid_in && state_r == STL_SKIP;
	wire mbit_zero = ~mem_nibble_in[bit_sel];
	wire port_zero = ~port_d_in[reg_y_in[STL_Y_MSB:0]];
	wire do_mbit   = in_exec && is_mbit;
	wire do_carry  = in_exec && is_carry;
	wire do_port2  = instr_valid_in && state_r == STL_PORT2;       // second word
	wire do_tload  = in_exec && is_tload;
	wire skip_now  = (do_mbit && mbit_zero) || (do_carry && !carry_flag_in)
		|| (do_port2 && port_zero);
	wire [STL_TW-1:0] load_val = {aux_in, acc_in};

	// sequencing: port skip spans two words, a skip swallows the next word
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			STL_EXEC: begin
				if (in_exec && is_port) begin
					state_nxt = STL_PORT2;
				end else if (skip_now) begin
					state_nxt = STL_SKIP;
				end
			end
			STL_PORT2: begin
				if (do_port2) begin
					state_nxt = port_zero ? STL_SKIP : STL_EXEC;
				end
			end
			STL_SKIP: begin
				if (in_skip) begin
					state_nxt = STL_EXEC;
				end
			end
			default: state_nxt = STL_EXEC;
		endcase
	end

	// state and status flops
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_r <= STL_EXEC;
			skip_r  <= 1'b0;
			busy_r  <= 1'b0;
			carry_r <= 1'b0;
			tload_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			skip_r  <= state_nxt == STL_SKIP;
			busy_r  <= state_nxt == STL_PORT2;
			carry_r <= carry_flag_in;
			tload_r <= do_tload;
		end
	end

	// timer 1 count and reload, written together
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			count_r  <= STL_TIMER_RST;
			reload_r <= STL_TIMER_RST;
		end else if (do_tload) begin
			count_r  <= load_val;
			reload_r <= load_val;
		end
	end

	assign skip_out             = skip_r;
	assign busy_out             = busy_r;
	assign carry_flag_out       = carry_r;
	assign timer_load_out       = tload_r;
	assign timer_one_count_out  = count_r;
	assign timer_one_reload_out = reload_r;

	property p_mbit_skip;
		@(posedge ref_clk_in) disable iff (!rst_n_in) do_mbit && mbit_zero |=> skip_out;
	endproperty
	a_mbit_skip: assert property (p_mbit_skip) else $error("mem bit zero did not skip");

	property p_mbit_noskip;
		@(posedge ref_clk_in) disable iff (!rst_n_in) do_mbit && !mbit_zero |=> !skip_out;
	endproperty
	a_mbit_noskip: assert property (p_mbit_noskip) else $error("mem bit one skipped");

	property p_carry;
		@(posedge ref_clk_in) disable iff (!rst_n_in)
			do_carry |=> skip_out == !$past(carry_flag_in) && carry_flag_out == $past(carry_flag_in);
	endproperty
	a_carry: assert property (p_carry) else $error("carry skip wrong");

	property p_port_skip;
		@(posedge ref_clk_in) disable iff (!rst_n_in)
			in_exec && is_port |=> busy_out && !skip_out;
	endproperty
	a_port_skip: assert property (p_port_skip) else $error("port skip not two words");

	property p_port_noskip;
		@(posedge ref_clk_in) disable iff (!rst_n_in) do_port2 |=> skip_out == $past(port_zero);
	endproperty
	a_port_noskip: assert property (p_port_noskip) else $error("port skip decision wrong");

	property p_tload_hi;
		@(posedge ref_clk_in) disable iff (!rst_n_in)
			do_tload |=> timer_one_count_out[7:4] == $past(aux_in) && timer_one_reload_out[7:4] == $past(aux_in);
	endproperty
	a_tload_hi: assert property (p_tload_hi) else $error("timer upper nibble wrong");

	property p_tload_lo;
		@(posedge ref_clk_in) disable iff (!rst_n_in)
			do_tload |=> timer_one_count_out[3:0] == $past(acc_in) && timer_one_reload_out[3:0] == $past(acc_in);
	endproperty
	a_tload_lo: assert property (p_tload_lo) else $error("timer lower nibble wrong");

	property p_skip_nop;
		@(posedge ref_clk_in) disable iff (!rst_n_in)
			skip_out && instr_valid_in |=> $stable(timer_one_count_out) && !skip_out && !timer_load_out;
	endproperty
	a_skip_nop: assert property (p_skip_nop) else $error("skipped word had effect");

	// a pending skip waits for a real word, idle cycles must not use it up
	property p_skip_hold;
		@(posedge ref_clk_in) disable iff (!rst_n_in)
			skip_out && !instr_valid_in |=> skip_out;
	endproperty
	a_skip_hold: assert property (p_skip_hold) else $error("skip dropped without a word");

	// a swallowed port skip opcode must not open its second word
	property p_skip_no_busy;
		@(posedge ref_clk_in) disable iff (!rst_n_in)
			skip_out && instr_valid_in |=> !busy_out;
	endproperty
	a_skip_no_busy: assert property (p_skip_no_busy) else $error("skipped port word went busy");

	// the port skip keeps waiting for its second word across idle cycles
	property p_busy_hold;
		@(posedge ref_clk_in) disable iff (!rst_n_in)
			busy_out && !instr_valid_in |=> busy_out && !skip_out;
	endproperty
	a_busy_hold: assert property (p_busy_hold) else $error("port skip lost its second word");

	// the second word always closes the port skip
	property p_port_end;
		@(posedge ref_clk_in) disable iff (!rst_n_in)
			do_port2 |=> !busy_out;
	endproperty
	a_port_end: assert property (p_port_end) else $error("port skip longer than two words");

	// a port bit of one lets the next word run
	property p_port_one;
		@(posedge ref_clk_in) disable iff (!rst_n_in)
			do_port2 && !port_zero |=> !skip_out;
	endproperty
	a_port_one: assert property (p_port_one) else $error("port bit one skipped");

	// memory-bit skip is a single word
	property p_mbit_one_word;
		@(posedge ref_clk_in) disable iff (!rst_n_in)
			do_mbit |=> !busy_out;
	endproperty
	a_mbit_one_word: assert property (p_mbit_one_word) else $error("mem bit skip took two words");

	// carry skip is a single word
	property p_carry_one_word;
		@(posedge ref_clk_in) disable iff (!rst_n_in)
			do_carry |=> !busy_out;
	endproperty
	a_carry_one_word: assert property (p_carry_one_word) else $error("carry skip took two words");

	// the load pulse follows every executed timer load
	property p_tload_pulse;
		@(posedge ref_clk_in) disable iff (!rst_n_in)
			do_tload |=> timer_load_out;
	endproperty
	a_tload_pulse: assert property (p_tload_pulse) else $error("timer load pulse missing");

	// timer and reload only move on an executed load
	property p_timer_hold;
		@(posedge ref_clk_in) disable iff (!rst_n_in)
			!do_tload |=> $stable(timer_one_count_out) && $stable(timer_one_reload_out) && !timer_load_out;
	endproperty
	a_timer_hold: assert property (p_timer_hold) else $error("timer changed without a load");

	// waiting for a second word and skipping never overlap
	property p_skip_busy_excl;
		@(posedge ref_clk_in) disable iff (!rst_n_in)
			!(skip_out && busy_out);
	endproperty
	a_skip_busy_excl: assert property (p_skip_busy_excl) else $error("skip and busy together");
endmodule

// ===== tb_stl_core.sv
// self-checking testbench for the skip and timer-load block
`timescale 1ns/1ns
module tb_stl_core;
	import stl_pkg::*;
	logic        clk, rst_n, vld, carry, skip, busy, carry_o, tl;
	logic [9:0]  ins;
	logic [3:0]  mem, y, acc, aux;
	logic [7:0]  port, cnt, rld;
	int          fail_count, n_tests;

	stl_core #(.PORT_W(8)) u_stl_core (.ref_clk_in(clk), .rst_n_in(rst_n), .instr_valid_in(vld),
		.instr_in(ins), .mem_nibble_in(mem), .carry_flag_in(carry), .port_d_in(port), .reg_y_in(y),
		.acc_in(acc), .aux_in(aux), .skip_out(skip), .busy_out(busy), .carry_flag_out(carry_o),
		.timer_load_out(tl), .timer_one_count_out(cnt), .timer_one_reload_out(rld));

	// 250 MHz core clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// compare one value and count the outcome
	task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// one valid word taken at a rising edge, outputs settled at the next falling edge
	task automatic step(input logic [9:0] w);
		@(negedge clk);
		vld = 1'b1;
		ins = w;
		@(negedge clk);
		vld = 1'b0;
	endtask

	// memory-bit skip for every j, bit zero and bit one; the word after is consumed
	task automatic t_mbit;
		for (int j = 0; j < 4; j++) begin
			for (int b = 0; b < 2; b++) begin
				mem = b ? (4'h1 << j) : ~(4'h1 << j);
				step(STL_OP_MBIT | 10'(j));
				chk("mem skip", skip, {7'h00, ~b[0]});
				step(10'h000);
				chk("mem skip cleared", skip, 8'h00);
			end
		end
		$display("memory-bit skip test done");
	endtask

	// carry skip, one cycle, carry left as it was
	task automatic t_carry;
		for (int c = 0; c < 2; c++) begin
			carry = c[0];
			step(STL_OP_CARRY);
			chk("carry skip", skip, {7'h00, ~c[0]});
			chk("carry kept", carry_o, {7'h00, c[0]});
			step(10'h000);
		end
		$display("carry skip test done");
	endtask

	// port skip for every Y, two words, Y bit 3 must not matter
	task automatic t_port;
		for (int i = 0; i < 8; i++) begin
			for (int b = 0; b < 2; b++) begin
				port = b ? (8'h01 << i) : ~(8'h01 << i);
				y = {b[0], i[2:0]};
				step(STL_OP_PORT);
				chk("port busy", busy, 8'h01);
				chk("port early skip", skip, 8'h00);
				step(10'h000);
				chk("port busy end", busy, 8'h00);
				chk("port skip", skip, {7'h00, ~b[0]});
				step(10'h000);
			end
		end
		$display("port skip test done");
	endtask

	// timer load, then a load swallowed by a skip, then a real second load
	task automatic t_tload;
		acc = 4'h5;
		aux = 4'hA;
		step(STL_OP_TLOAD);
		chk("load pulse", tl, 8'h01);
		chk("count", cnt, 8'hA5);
		chk("reload", rld, 8'hA5);
		carry = 1'b0;
		step(STL_OP_CARRY);
		acc = 4'h3;
		aux = 4'hC;
		step(STL_OP_TLOAD);
		chk("skipped load pulse", tl, 8'h00);
		chk("skipped load count", cnt, 8'hA5);
		step(STL_OP_TLOAD);
		chk("count 2", cnt, 8'hC3);
		chk("reload 2", rld, 8'hC3);
		$display("timer load test done");
	endtask

	// a swallowed port skip and a swallowed carry skip leave no trace
	task automatic t_swallow;
		carry = 1'b0;
		step(STL_OP_CARRY);
		step(STL_OP_PORT);
		chk("swallowed port busy", busy, 8'h00);
		chk("swallowed port skip", skip, 8'h00);
		step(STL_OP_CARRY);
		chk("carry skip again", skip, 8'h01);
		step(STL_OP_CARRY);
		chk("swallowed carry skip", skip, 8'h00);
		$display("swallow test done");
	endtask

	// reset in mid-run with a skip pending, then a load that must not be swallowed
	task automatic t_reset;
		carry = 1'b0;
		step(STL_OP_CARRY);
		chk("skip before reset", skip, 8'h01);
		rst_n = 1'b0;
		@(negedge clk);
		chk("skip in reset", skip, 8'h00);
		chk("count in reset", cnt, STL_TIMER_RST);
		chk("reload in reset", rld, STL_TIMER_RST);
		rst_n = 1'b1;
		acc = 4'h9;
		aux = 4'h6;
		step(STL_OP_TLOAD);
		chk("load after reset", cnt, 8'h69);
		chk("reload after reset", rld, 8'h69);
		$display("mid-run reset test done");
	endtask

	// counts, verdict and end of run
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// watchdog against a hang
	initial begin
		#20000;
		fail_count++;
		conclude();
	end

	// reset, then the scenarios
	initial begin
		{rst_n, vld, carry, ins, mem, y, acc, aux, port} = '0;
		fail_count = 0;
		n_tests = 0;
		repeat (2) @(posedge clk);
		@(negedge clk);
		rst_n = 1'b1;
		chk("count at reset", cnt, STL_TIMER_RST);
		t_mbit();
		t_carry();
		t_port();
		t_tload();
		t_swallow();
		t_reset();
		conclude();
	end
endmodule
